/* inc/vdsr_pkg.sv */
// Behaviour
// - Hue value is signed two's complement, about 0.35 degree a step, +-45 degrees.
// - Hue value resets to zero, meaning no hue rotation.
// - Writing one to a request bit arms that decode and waits for data.
// - Finished decode stores its two bytes and sets its ready flag at 0x10.
// - Request register is write-only; bits 0..2 request caption, extended, blanking id.
// - Writing one to any request bit clears all three ready flags first.
// - Delay code: 000 none; 101/110/111 delay 3/1/1; 001/010/011 advance 2/2/3.
// - Delay unit is 12.2727MHz cycle in wide modes, else 13.5MHz cycle.
// - Status bit 0 reads one when no input signal is present.
// - Status bit 1 reads one while colour killer is active.
// - Status bit 2 reads one on converter input overflow.
// - Status bit 3 reads one when vertical lock is lost.
// - Status bit 4 reads zero in sync gain mode, one in peak mode.
// - Status bit 5 reads one while caption bytes are held.
// - Status bit 6 reads one while extended bytes are held.
// - Status bit 7 reads one while blanking id bytes are held.
// - Data bytes read at 0x12/0x13, 0x14/0x15, 0x16/0x17.
`default_nettype none
package vdsr_pkg;
  // Serial bus address of the device; value is arbitrary
  localparam logic [6:0] VDSR_DEV_ADDR = 7'h21;
  localparam logic [7:0] VDSR_SA_HUE = 8'h09;
  localparam logic [7:0] VDSR_SA_REQ = 8'h0a;
  localparam logic [7:0] VDSR_SA_DELAY = 8'h0b;
  localparam logic [7:0] VDSR_SA_STATUS = 8'h10;
  localparam logic [7:0] VDSR_SA_CC_LO = 8'h12;
  localparam logic [7:0] VDSR_SA_CC_HI = 8'h13;
  localparam logic [7:0] VDSR_SA_EXT_LO = 8'h14;
  localparam logic [7:0] VDSR_SA_EXT_HI = 8'h15;
  localparam logic [7:0] VDSR_SA_BID_LO = 8'h16;
  localparam logic [7:0] VDSR_SA_BID_HI = 8'h17;
  localparam logic [7:0] VDSR_HUE_RST = 8'h00;
  localparam logic [2:0] VDSR_DELAY_RST = 3'h0;
  localparam logic [15:0] VDSR_DATA_RST = 16'h0000;
  localparam logic [7:0] VDSR_RD_ZERO = 8'h00;
  localparam int VDSR_NKIND = 3;
  localparam int VDSR_REQ_CC = 0;
  localparam int VDSR_REQ_EXT = 1;
  localparam int VDSR_REQ_BID = 2;
  localparam int VDSR_DLY_W = 3;
  localparam logic [3:0] VDSR_BIT_LAST = 4'h7;
  localparam logic [3:0] VDSR_BIT_ACK = 4'h8;
  localparam logic [3:0] VDSR_BIT_ONE = 4'h1;
  localparam logic [3:0] VDSR_BIT_FIRST = 4'h0;
  typedef enum logic [2:0] {
    VDSR_ST_IDLE,
    VDSR_ST_ADDR,
    VDSR_ST_SUB,
    VDSR_ST_WR,
    VDSR_ST_RD
  } vdsr_state_t;
endpackage : vdsr_pkg
`default_nettype wire

/* rtl/vdsr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module vdsr_regs
  import vdsr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic input_absent_in,
  input wire logic chroma_suppress_active_in,
  input wire logic input_overflow_in,
  input wire logic vertical_lock_lost_in,
  input wire logic gain_mode_indicator_in,
  input wire logic wide_mode_in,
  input wire logic [VDSR_NKIND-1:0] decode_done_in,
  input wire logic [15:0] caption_bytes_in,
  input wire logic [15:0] extended_bytes_in,
  input wire logic [15:0] blanking_id_bytes_in,
  output logic signed [7:0] hue_adjust_out,
  output logic [VDSR_NKIND-1:0] decode_armed_out,
  output logic signed [2:0] luma_offset_cycles_out,
  output logic luma_offset_unit_wide_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a change counts when stages two and three agree
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_f_q <= sda_sync_q[2];
      end
    end
  end

  wire scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
  wire sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
  assign scl_rise = scl_new & ~scl_f_q;
  assign scl_fall = ~scl_new & scl_f_q;
  assign bus_start = scl_f_q & scl_new & sda_f_q & ~sda_new;
  assign bus_stop = scl_f_q & scl_new & ~sda_f_q & sda_new;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] hue_q;
  logic [VDSR_DLY_W-1:0] delay_q;
  logic [VDSR_NKIND-1:0] armed_q;
  logic [VDSR_NKIND-1:0] ready_q;
  logic [4:0] cond_q;
  logic [15:0] cc_q;
  logic [15:0] ext_q;
  logic [15:0] bid_q;
  logic [7:0] sub_q;
  logic wr_en;
  logic [7:0] wr_data;
  logic req_hit;
  logic [VDSR_NKIND-1:0] done_hit;

  function automatic logic [7:0] vdsr_read(input logic [7:0] sa);
    logic [7:0] v;
    v = VDSR_RD_ZERO;
    unique case (sa)
      VDSR_SA_HUE: v = hue_q;
      VDSR_SA_DELAY: v = {5'h00, delay_q};
      VDSR_SA_STATUS: v = {ready_q, cond_q};
      VDSR_SA_CC_LO: v = cc_q[7:0];
      VDSR_SA_CC_HI: v = cc_q[15:8];
      VDSR_SA_EXT_LO: v = ext_q[7:0];
      VDSR_SA_EXT_HI: v = ext_q[15:8];
      VDSR_SA_BID_LO: v = bid_q[7:0];
      VDSR_SA_BID_HI: v = bid_q[15:8];
      // Request register is write-only, so it reads as zero
      default: v = VDSR_RD_ZERO;
    endcase
    return v;
  endfunction

  // Signed luma shift in delay units; positive means luma later than chroma
  function automatic logic signed [2:0] vdsr_offset(input logic [2:0] code);
    logic signed [2:0] o;
    o = 3'sd0;
    unique case (code)
      3'b101: o = 3'sd3;
      3'b110: o = 3'sd1;
      3'b111: o = 3'sd1;
      3'b001: o = -3'sd2;
      3'b010: o = -3'sd2;
      3'b011: o = -3'sd3;
      default: o = 3'sd0;
    endcase
    return o;
  endfunction

  // Read data for this and the next sub-address, ready for the shifter
  logic [7:0] sub_inc;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  always_comb begin
    sub_inc = sub_q + 8'h01;
    rd_cur = vdsr_read(sub_q);
    rd_nxt = vdsr_read(sub_inc);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus slave
  vdsr_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic mack_q;
  logic sda_oe_q;
  logic sda_out_q;

  assign wr_en = scl_fall && (bit_q == VDSR_BIT_LAST) && (state_q == VDSR_ST_WR);
  assign wr_data = shift_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= VDSR_ST_IDLE;
      bit_q <= VDSR_BIT_FIRST;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b1;
      sda_oe_q <= 1'b0;
      sub_q <= 8'h00;
    end else if (bus_start) begin
      state_q <= VDSR_ST_ADDR;
      // Clock fall closing the start is no bit, so it brings the count to the first bit
      bit_q <= VDSR_BIT_FIRST - VDSR_BIT_ONE;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= VDSR_ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (state_q != VDSR_ST_IDLE) begin
      if (scl_rise) begin
        if (bit_q == VDSR_BIT_ACK) begin
          mack_q <= sda_new;
        end else if (state_q != VDSR_ST_RD) begin
          shift_q <= {shift_q[6:0], sda_new};
        end
      end else if (scl_fall) begin
        if (bit_q == VDSR_BIT_LAST) begin
          bit_q <= VDSR_BIT_ACK;
          unique case (state_q)
            VDSR_ST_ADDR: begin
              if (shift_q[7:1] == VDSR_DEV_ADDR) begin
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
              end else begin
                state_q <= VDSR_ST_IDLE;
              end
            end
            VDSR_ST_SUB: begin
              sub_q <= shift_q;
              sda_oe_q <= 1'b1;
            end
            VDSR_ST_WR: begin
              sda_oe_q <= 1'b1;
            end
            VDSR_ST_RD: begin
              // Let the master answer in the ack slot
              sda_oe_q <= 1'b0;
            end
            default: state_q <= VDSR_ST_IDLE;
          endcase
        end else if (bit_q == VDSR_BIT_ACK) begin
          bit_q <= VDSR_BIT_FIRST;
          sda_oe_q <= 1'b0;
          unique case (state_q)
            VDSR_ST_ADDR: begin
              if (rw_q) begin
                state_q <= VDSR_ST_RD;
                shift_q <= rd_cur;
                sda_oe_q <= ~rd_cur[7];
              end else begin
                state_q <= VDSR_ST_SUB;
              end
            end
            VDSR_ST_SUB: state_q <= VDSR_ST_WR;
            VDSR_ST_WR: sub_q <= sub_q + 8'h01;
            VDSR_ST_RD: begin
              // Master nack ends the read; auto-increment on ack
              if (mack_q) begin
                state_q <= VDSR_ST_IDLE;
              end else begin
                sub_q <= sub_inc;
                shift_q <= rd_nxt;
                sda_oe_q <= ~rd_nxt[7];
              end
            end
            default: state_q <= VDSR_ST_IDLE;
          endcase
        end else begin
          bit_q <= bit_q + VDSR_BIT_ONE;
          if (state_q == VDSR_ST_RD) begin
            shift_q <= {shift_q[6:0], 1'b0};
            sda_oe_q <= ~shift_q[6];
          end
        end
      end
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hue_q <= VDSR_HUE_RST;
      delay_q <= VDSR_DELAY_RST;
    end else if (wr_en) begin
      if (sub_q == VDSR_SA_HUE) begin
        hue_q <= wr_data;
      end
      if (sub_q == VDSR_SA_DELAY) begin
        delay_q <= wr_data[VDSR_DLY_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blanking data requests and ready flags
  assign req_hit = wr_en && (sub_q == VDSR_SA_REQ) && (|wr_data[VDSR_NKIND-1:0]);
  assign done_hit = decode_done_in & armed_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed_q <= '0;
      ready_q <= '0;
    end else begin
      // A decode that lands with the clearing write still raises its flag
      armed_q <= (armed_q & ~done_hit) |
                 (req_hit ? wr_data[VDSR_NKIND-1:0] : '0);
      ready_q <= (req_hit ? '0 : ready_q) | done_hit;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cc_q <= VDSR_DATA_RST;
      ext_q <= VDSR_DATA_RST;
      bid_q <= VDSR_DATA_RST;
    end else begin
      if (done_hit[VDSR_REQ_CC]) begin
        cc_q <= caption_bytes_in;
      end
      if (done_hit[VDSR_REQ_EXT]) begin
        ext_q <= extended_bytes_in;
      end
      if (done_hit[VDSR_REQ_BID]) begin
        bid_q <= blanking_id_bytes_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live decoder conditions and outputs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cond_q <= 5'h00;
    end else begin
      cond_q <= {gain_mode_indicator_in,
                 vertical_lock_lost_in,
                 input_overflow_in,
                 chroma_suppress_active_in,
                 input_absent_in};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hue_adjust_out <= 8'sh00;
      decode_armed_out <= '0;
      luma_offset_cycles_out <= 3'sd0;
      luma_offset_unit_wide_out <= 1'b0;
    end else begin
      hue_adjust_out <= $signed(hue_q);
      decode_armed_out <= armed_q;
      luma_offset_cycles_out <= vdsr_offset(delay_q);
      luma_offset_unit_wide_out <= wide_mode_in;
    end
  end

  assign sda_oe_out = sda_oe_q;
  assign sda_out = sda_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking vdsr_cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  AST_HUE_WRITE: assert property (
    wr_en && sub_q == VDSR_SA_HUE |=> ##1 hue_adjust_out == $signed($past(wr_data, 2)))
    else $error("hue write not reflected");
  AST_REQ_CLEARS: assert property (
    req_hit && decode_done_in == '0 |=> ready_q == '0)
    else $error("request did not clear ready flags");
  AST_REQ_ARMS: assert property (
    req_hit |=> (armed_q & $past(wr_data[2:0])) == $past(wr_data[2:0]))
    else $error("request did not arm decode");
  AST_DONE_SETS: assert property (
    done_hit[VDSR_REQ_CC] |=> ready_q[VDSR_REQ_CC] && cc_q == $past(caption_bytes_in))
    else $error("caption decode not stored");
  AST_IDLE_IGNORE: assert property (
    decode_done_in[VDSR_REQ_EXT] && !armed_q[VDSR_REQ_EXT] |=> $stable(ext_q))
    else $error("unrequested data captured");
  AST_FLAG_HOLDS: assert property (
    ready_q[VDSR_REQ_BID] && !req_hit |=> ready_q[VDSR_REQ_BID])
    else $error("ready flag dropped without request");
  AST_STATUS_LIVE: assert property (
    1'b1 |=> cond_q == $past({gain_mode_indicator_in, vertical_lock_lost_in,
                              input_overflow_in, chroma_suppress_active_in,
                              input_absent_in}))
    else $error("status conditions not tracked");
  AST_DELAY_CODE: assert property (
    delay_q == 3'b011 ##1 delay_q == 3'b011 |-> luma_offset_cycles_out == -3'sd3)
    else $error("delay code decoded wrongly");
  AST_STATUS_READ: assert property (
    sub_q == VDSR_SA_STATUS |-> rd_cur[5] == ready_q[VDSR_REQ_CC])
    else $error("status bit 5 mismatch");

  COV_REQ_DONE: cover property (req_hit ##[1:100] done_hit[VDSR_REQ_CC]);
  COV_READ: cover property (state_q == VDSR_ST_RD && scl_fall && bit_q == VDSR_BIT_ACK);
  COV_SET_CLEAR: cover property (req_hit && done_hit != '0);

endmodule // vdsr_regs
`default_nettype wire

/* verification/vdsr_host.sv */
`timescale 1ns/10ps
`default_nettype none
module vdsr_host (
  input wire logic clk_sys_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Eight clocks a phase, well clear of the input filter lag
  task automatic tick();
    repeat (8) @(posedge clk_sys_in);
  endtask
  // Also serves as repeated start, since clock is low between bytes
  task automatic start();
    sda_low_out <= 1'b0;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_low_out <= 1'b1;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_low_out <= 1'b0;
    tick();
  endtask
  // Data only moves while the clock is low; sampled at end of high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low_out <= ~b;
    tick();
    scl_out <= 1'b1;
    tick();
    r = sda_in;
    scl_out <= 1'b0;
    tick();
  endtask
  task automatic wr8(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Last byte is refused so the device lets go of the line
  task automatic rd8(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v = {v[6:0], r};
    end
    bit_x(last, r);
  endtask
endmodule // vdsr_host
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb
  import vdsr_pkg::*;
;
  logic clk_sys_in, rst_b_in, scl, host_low, sda_d, sda_oe, wide, unit_w, ack;
  logic sda_w;
  logic [4:0] stat_v;
  logic [2:0] done_v, armed, off_tab [8];
  logic signed [2:0] offs;
  logic [15:0] cc_v, ext_v, bid_v;
  logic signed [7:0] hue_o;
  logic [7:0] rd;
  int err_count, compares;
  // Open-drain wire with pull-up
  assign sda_w = !((sda_oe && !sda_d) || host_low);
  vdsr_regs DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_d), .sda_oe_out(sda_oe),
    .input_absent_in(stat_v[0]), .chroma_suppress_active_in(stat_v[1]),
    .input_overflow_in(stat_v[2]), .vertical_lock_lost_in(stat_v[3]),
    .gain_mode_indicator_in(stat_v[4]), .wide_mode_in(wide), .decode_done_in(done_v),
    .caption_bytes_in(cc_v), .extended_bytes_in(ext_v), .blanking_id_bytes_in(bid_v),
    .hue_adjust_out(hue_o), .decode_armed_out(armed), .luma_offset_cycles_out(offs),
    .luma_offset_unit_wide_out(unit_w));
  vdsr_host host (.clk_sys_in(clk_sys_in), .sda_in(sda_w), .scl_out(scl),
    .sda_low_out(host_low));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [7:0] sa, input logic [7:0] d);
    host.start();
    host.wr8({VDSR_DEV_ADDR, 1'b0}, ack);
    `CHK(ack, 1'b1)
    host.wr8(sa, ack);
    host.wr8(d, ack);
    `CHK(ack, 1'b1)
    host.stop();
  endtask
  task automatic chk_reg(input logic [7:0] sa, input logic [7:0] exp);
    host.start();
    host.wr8({VDSR_DEV_ADDR, 1'b0}, ack);
    host.wr8(sa, ack);
    host.start();
    host.wr8({VDSR_DEV_ADDR, 1'b1}, ack);
    host.rd8(1'b1, rd);
    host.stop();
    `CHK(rd, exp)
  endtask
  // Bytes change right after the pulse, so held values prove capture
  task automatic pulse(input logic [2:0] m, input logic [15:0] d);
    @(posedge clk_sys_in);
    done_v <= m;
    cc_v <= d;
    ext_v <= ~d;
    bid_v <= {d[7:0], d[15:8]};
    @(posedge clk_sys_in);
    done_v <= 3'h0;
    cc_v <= 16'h0000;
    ext_v <= 16'h0000;
    bid_v <= 16'h0000;
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #8000000;
    err_count++;
    wrap_up();
  end
  initial begin
    rst_b_in = 1'b0;
    stat_v = 5'h00;
    done_v = 3'h0;
    cc_v = 16'h0000;
    ext_v = 16'h0000;
    bid_v = 16'h0000;
    wide = 1'b0;
    off_tab = '{3'h0, 3'h6, 3'h6, 3'h5, 3'h0, 3'h3, 3'h1, 3'h1};
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk_reg(VDSR_SA_HUE, 8'h00);
    `CHK(hue_o, 8'h00)
    chk_reg(VDSR_SA_DELAY, 8'h00);
    chk_reg(VDSR_SA_REQ, 8'h00);
    chk_reg(VDSR_SA_STATUS, 8'h00);
    $display("test reset done");
    wreg(VDSR_SA_HUE, 8'h80);
    `CHK(hue_o, 8'h80)
    wreg(VDSR_SA_HUE, 8'h7f);
    chk_reg(VDSR_SA_HUE, 8'h7f);
    `CHK(hue_o, 8'h7f)
    wreg(VDSR_SA_STATUS, 8'hff);
    chk_reg(VDSR_SA_STATUS, 8'h00);
    chk_reg(8'h30, 8'h00);
    $display("test hue done");
    for (int c = 0; c < 8; c++) begin
      if (c != 4) begin
        wreg(VDSR_SA_DELAY, {5'h1f, c[2:0]});
        chk_reg(VDSR_SA_DELAY, {5'h00, c[2:0]});
        `CHK(offs, off_tab[c])
      end
    end
    wide <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    `CHK(unit_w, 1'b1)
    wide <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    `CHK(unit_w, 1'b0)
    $display("test delay done");
    for (int i = 0; i < 5; i++) begin
      stat_v <= 5'h01 << i;
      chk_reg(VDSR_SA_STATUS, 8'h01 << i);
    end
    stat_v <= 5'h00;
    $display("test status done");
    wreg(VDSR_SA_REQ, 8'h01);
    `CHK(armed, 3'h1)
    pulse(3'h7, 16'hbeef);
    chk_reg(VDSR_SA_STATUS, 8'h20);
    `CHK(armed, 3'h0)
    chk_reg(VDSR_SA_CC_LO, 8'hef);
    chk_reg(VDSR_SA_CC_HI, 8'hbe);
    host.start();
    host.wr8({VDSR_DEV_ADDR, 1'b0}, ack);
    host.wr8(VDSR_SA_CC_LO, ack);
    host.start();
    host.wr8({VDSR_DEV_ADDR, 1'b1}, ack);
    host.rd8(1'b0, rd);
    `CHK(rd, 8'hef)
    host.rd8(1'b1, rd);
    `CHK(rd, 8'hbe)
    host.stop();
    chk_reg(VDSR_SA_EXT_LO, 8'h00);
    wreg(VDSR_SA_REQ, 8'h00);
    chk_reg(VDSR_SA_STATUS, 8'h20);
    wreg(VDSR_SA_REQ, 8'h06);
    chk_reg(VDSR_SA_STATUS, 8'h00);
    `CHK(armed, 3'h6)
    pulse(3'h6, 16'h1234);
    chk_reg(VDSR_SA_STATUS, 8'hc0);
    chk_reg(VDSR_SA_EXT_LO, 8'hcb);
    chk_reg(VDSR_SA_EXT_HI, 8'hed);
    chk_reg(VDSR_SA_BID_LO, 8'h12);
    chk_reg(VDSR_SA_BID_HI, 8'h34);
    chk_reg(VDSR_SA_CC_LO, 8'hef);
    $display("test decode done");
    host.start();
    host.wr8({VDSR_DEV_ADDR ^ 7'h01, 1'b0}, ack);
    `CHK(ack, 1'b0)
    host.stop();
    $display("test address done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
